/* File: inc/tt2_pkg.sv */
package tt2_pkg;

  // special-function register addresses
  localparam logic [7:0] ADDR_CTRL   = 8'hc8;
  localparam logic [7:0] ADDR_CAP_LO = 8'hca;
  localparam logic [7:0] ADDR_CAP_HI = 8'hcb;
  localparam logic [7:0] ADDR_CNT_LO = 8'hcc;
  localparam logic [7:0] ADDR_CNT_HI = 8'hcd;

  // timer_two_control bit positions
  localparam int BIT_OVERFLOW_FLAG = 7;
  localparam int BIT_EXTERNAL_FLAG = 6;
  localparam int BIT_RECEIVE_CLK   = 5;
  localparam int BIT_TRANSMIT_CLK  = 4;
  localparam int BIT_EXT_ENABLE    = 3;
  localparam int BIT_RUN_CONTROL   = 2;
  localparam int BIT_COUNTER_SEL   = 1;
  localparam int BIT_CAPTURE_SEL   = 0;

  // values after reset
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] CAP_RESET   = 16'h0000;
  localparam logic [7:0]  RDATA_IDLE  = 8'h00;

  // count value at which the next tick rolls over
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  // pin synchroniser depth before any logic looks at a pin
  localparam int SYNC_STAGES = 2;

endpackage

/* File: hw/tt2_fall_detect.sv */
`timescale 1ns/10ps
module tt2_fall_detect (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level,
  output logic      fall
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  // meta_q feeds sync_q and nothing else
  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // falling edge from two successive synchronised samples
  assign level = sync_q;
  assign fall  = prev_q & ~sync_q;

endmodule

/* File: hw/tt2_timer.sv */
// Behaviour
// - capture mode, no enable: overflow sets flag
// - trigger falling edge captures count into capture bytes
// - capturing edge sets external flag, may interrupt
// - either serial clock select bit gives baud mode
// - serial clock select blocks overflow flag setting
// - baud mode: trigger edge still sets external flag
// - overflow flag set by hardware, cleared by software
// - external flag set on enabled edge, software clears
// - receive select picks this or other overflow
// - transmit select picks this or other overflow
// - enable gates trigger edges; ignored when cleared
// - counts only while run control is set
// - counter select: pin edges, else core clock
// - capture select chooses mode; baud forces reload
// - count bytes live, capture bytes capture/reload
// - autoreload: rollover sets flag, reloads count
// - autoreload with enable: trigger edge reloads, flags
`timescale 1ns/10ps
module tt2_timer (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  output logic            sfr_sel,
  input  wire logic       count_pin,
  input  wire logic       trigger_pin,
  input  wire logic       timer1_overflow,
  output logic            rx_clock_pulse,
  output logic            tx_clock_pulse,
  output logic            overflow_pulse,
  output logic            overflow_flag,
  output logic            external_flag
);

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] r);
    addr_is = (a == r);
  endfunction

  logic [7:0]  ctrl_q, ctrl_d;
  logic [15:0] count_q, count_d;
  logic [15:0] cap_q, cap_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rx_q, rx_d;
  logic        tx_q, tx_d;
  logic        ovp_q, ovp_d;

  logic        run, cnt_sel, cap_sel, exen, rclk_sel, transmit_clock_select_sel, baud;
  logic        count_fall, trig_fall;
  logic        tick, ovf, trig_evt, do_capture, do_trig_reload, do_reload;
  logic        wr_ctrl, wr_cap_lo, wr_cap_hi, wr_cnt_lo, wr_cnt_hi, wr_cnt;
  logic [7:0]  read_mux;

  tt2_fall_detect u_count_pin (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (count_pin),
    .level   (),
    .fall    (count_fall)
  );

  tt2_fall_detect u_trigger_pin (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (trigger_pin),
    .level   (),
    .fall    (trig_fall)
  );

  assign run      = ctrl_q[tt2_pkg::BIT_RUN_CONTROL];
  assign cnt_sel  = ctrl_q[tt2_pkg::BIT_COUNTER_SEL];
  assign cap_sel  = ctrl_q[tt2_pkg::BIT_CAPTURE_SEL];
  assign exen     = ctrl_q[tt2_pkg::BIT_EXT_ENABLE];
  assign rclk_sel = ctrl_q[tt2_pkg::BIT_RECEIVE_CLK];
  assign transmit_clock_select_sel = ctrl_q[tt2_pkg::BIT_TRANSMIT_CLK];

  assign baud = rclk_sel | transmit_clock_select_sel;

  // one count per core clock as timer, per synchronised pin fall as counter
  assign tick = run & (cnt_sel ? count_fall : 1'b1);
  assign ovf  = tick & (count_q == tt2_pkg::COUNT_MAX);

  // trigger edges are gated by the enable in every mode
  assign trig_evt       = trig_fall & exen;
  assign do_capture     = trig_evt & ~baud & cap_sel;
  assign do_trig_reload = trig_evt & ~baud & ~cap_sel;
  // baud mode ignores capture select and reloads on overflow
  assign do_reload      = (ovf & (baud | ~cap_sel)) | do_trig_reload;

  assign wr_ctrl   = sfr_wr & addr_is(sfr_addr, tt2_pkg::ADDR_CTRL);
  assign wr_cap_lo = sfr_wr & addr_is(sfr_addr, tt2_pkg::ADDR_CAP_LO);
  assign wr_cap_hi = sfr_wr & addr_is(sfr_addr, tt2_pkg::ADDR_CAP_HI);
  assign wr_cnt_lo = sfr_wr & addr_is(sfr_addr, tt2_pkg::ADDR_CNT_LO);
  assign wr_cnt_hi = sfr_wr & addr_is(sfr_addr, tt2_pkg::ADDR_CNT_HI);
  assign wr_cnt    = wr_cnt_lo | wr_cnt_hi;

  assign sfr_sel = addr_is(sfr_addr, tt2_pkg::ADDR_CTRL)
                 | addr_is(sfr_addr, tt2_pkg::ADDR_CAP_LO)
                 | addr_is(sfr_addr, tt2_pkg::ADDR_CAP_HI)
                 | addr_is(sfr_addr, tt2_pkg::ADDR_CNT_LO)
                 | addr_is(sfr_addr, tt2_pkg::ADDR_CNT_HI);

  always_comb begin
    read_mux = tt2_pkg::RDATA_IDLE;
    if (addr_is(sfr_addr, tt2_pkg::ADDR_CTRL)) begin
      read_mux = ctrl_q;
    end else if (addr_is(sfr_addr, tt2_pkg::ADDR_CAP_LO)) begin
      read_mux = cap_q[7:0];
    end else if (addr_is(sfr_addr, tt2_pkg::ADDR_CAP_HI)) begin
      read_mux = cap_q[15:8];
    end else if (addr_is(sfr_addr, tt2_pkg::ADDR_CNT_LO)) begin
      read_mux = count_q[7:0];
    end else if (addr_is(sfr_addr, tt2_pkg::ADDR_CNT_HI)) begin
      read_mux = count_q[15:8];
    end
  end

  // control register and its two sticky flags
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = sfr_wdata;
    end
    // a set in the same cycle as a software clear wins
    if (ovf && !baud) begin
      ctrl_d[tt2_pkg::BIT_OVERFLOW_FLAG] = 1'b1;
    end
    if (trig_evt) begin
      ctrl_d[tt2_pkg::BIT_EXTERNAL_FLAG] = 1'b1;
    end
  end

  // live count: software byte write beats the hardware update
  always_comb begin
    count_d = count_q;
    if (do_reload) begin
      count_d = cap_q;
    end else if (tick) begin
      count_d = count_q + 16'h0001;
    end
    if (wr_cnt_lo) begin
      count_d[7:0] = sfr_wdata;
    end
    if (wr_cnt_hi) begin
      count_d[15:8] = sfr_wdata;
    end
  end

  // capture/reload pair: a capture beats a software write so no event is lost
  always_comb begin
    cap_d = cap_q;
    if (wr_cap_lo) begin
      cap_d[7:0] = sfr_wdata;
    end
    if (wr_cap_hi) begin
      cap_d[15:8] = sfr_wdata;
    end
    if (do_capture) begin
      cap_d = count_q;
    end
  end

  // serial clock routing and read data, all registered
  always_comb begin
    rx_d    = rclk_sel ? ovf : timer1_overflow;
    tx_d    = transmit_clock_select_sel ? ovf : timer1_overflow;
    ovp_d   = ovf;
    rdata_d = sfr_rd ? read_mux : tt2_pkg::RDATA_IDLE;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_q  <= tt2_pkg::CTRL_RESET;
      count_q <= tt2_pkg::COUNT_RESET;
      cap_q   <= tt2_pkg::CAP_RESET;
      rdata_q <= tt2_pkg::RDATA_IDLE;
      rx_q    <= 1'b0;
      tx_q    <= 1'b0;
      ovp_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      count_q <= count_d;
      cap_q   <= cap_d;
      rdata_q <= rdata_d;
      rx_q    <= rx_d;
      tx_q    <= tx_d;
      ovp_q   <= ovp_d;
    end
  end

  assign sfr_rdata      = rdata_q;
  assign rx_clock_pulse = rx_q;
  assign tx_clock_pulse = tx_q;
  assign overflow_pulse = ovp_q;
  assign overflow_flag  = ctrl_q[tt2_pkg::BIT_OVERFLOW_FLAG];
  assign external_flag  = ctrl_q[tt2_pkg::BIT_EXTERNAL_FLAG];

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  property p_ovf_sets_flag;
    ovf && !baud |=> overflow_flag;
  endproperty
  a_ovf_sets_flag: assert property (p_ovf_sets_flag)
    else $error("overflow did not set overflow flag");

  property p_baud_no_flag;
    baud && !wr_ctrl && !overflow_flag |=> !overflow_flag;
  endproperty
  a_baud_no_flag: assert property (p_baud_no_flag)
    else $error("overflow flag set while clocking serial port");

  property p_flag_sticky;
    overflow_flag && !wr_ctrl |=> overflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("overflow flag cleared without software write");

  property p_capture;
    trig_evt && cap_sel && !baud |=> cap_q == $past(count_q);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture did not copy count");

  property p_ext_flag_set;
    trig_fall && exen |=> external_flag;
  endproperty
  a_ext_flag_set: assert property (p_ext_flag_set)
    else $error("enabled trigger edge did not set external flag");

  property p_ext_ignored;
    !exen && !wr_ctrl && !external_flag |=> !external_flag;
  endproperty
  a_ext_ignored: assert property (p_ext_ignored)
    else $error("external flag set with enable cleared");

  property p_stopped;
    !run && !wr_cnt && !do_trig_reload |=> $stable(count_q);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("count moved while stopped");

  property p_counter_waits;
    cnt_sel && !count_fall && !wr_cnt && !do_trig_reload |=> $stable(count_q);
  endproperty
  a_counter_waits: assert property (p_counter_waits)
    else $error("counter moved without pin edge");

  property p_reload;
    ovf && (baud || !cap_sel) && !wr_cnt |=> count_q == $past(cap_q);
  endproperty
  a_reload: assert property (p_reload)
    else $error("rollover did not reload count");

  property p_rx_route;
    (rclk_sel && ovf) || (!rclk_sel && timer1_overflow) |=> rx_clock_pulse;
  endproperty
  a_rx_route: assert property (p_rx_route)
    else $error("receive clock pulse missing");

  property p_tx_route;
    (transmit_clock_select_sel && ovf) || (!transmit_clock_select_sel && timer1_overflow) |=> tx_clock_pulse;
  endproperty
  a_tx_route: assert property (p_tx_route)
    else $error("transmit clock pulse missing");

  property p_fall_single;
    count_fall |=> !count_fall;
  endproperty
  a_fall_single: assert property (p_fall_single)
    else $error("pin fall lasted more than one cycle");

  c_capture: cover property (do_capture);
  c_ovf_reload: cover property (ovf && !cap_sel && !baud);
  c_baud_ovf: cover property (ovf && baud);
  c_baud_trigger: cover property (trig_evt && baud);

endmodule

/* File: dv/tt2_pins.sv */
`timescale 1ns/10ps
module tt2_pins (
  input  wire logic ref_clk,
  output logic      count_pin,
  output logic      trigger_pin,
  output logic      timer1_overflow
);
  // released pins float to the pull-up level
  initial begin
    count_pin = 1'b1;
    trigger_pin = 1'b1;
    timer1_overflow = 1'b0;
  end
  // len sets how slow the far side is; at 0 the pulse has no width and edges are lost
  task automatic fall(input int sel, input int len);
    @(negedge ref_clk);
    count_pin = (sel != 0);
    trigger_pin = (sel == 0);
    repeat (len) @(negedge ref_clk);
    count_pin = 1'b1;
    trigger_pin = 1'b1;
    repeat (len) @(negedge ref_clk);
  endtask
  task automatic t1_pulse();
    @(negedge ref_clk);
    timer1_overflow = 1'b1;
    @(negedge ref_clk);
    timer1_overflow = 1'b0;
  endtask
endmodule

/* File: dv/tb_timer_two_capture_reload.sv */
`timescale 1ns/10ps
module tb_timer_two_capture_reload;
  logic        ref_clk   = 1'b0;
  logic        resetn    = 1'b0;
  logic [7:0]  sfr_addr  = 8'h00;
  logic        sfr_wr    = 1'b0;
  logic        sfr_rd    = 1'b0;
  logic [7:0]  sfr_wdata = 8'h00;
  logic [7:0]  sfr_rdata, rv;
  logic        sfr_sel, count_pin, trigger_pin, timer1_overflow;
  logic        rx_clock_pulse, tx_clock_pulse, overflow_pulse, overflow_flag, external_flag;
  logic [31:0] seed      = 32'h317af9a0;
  logic [7:0]  modes [7] = '{8'h07, 8'h0f, 8'h06, 8'h0e, 8'h2f, 8'h1e, 8'h0b};
  int          miscompares = 0;
  int          n_checks    = 0;
  int          m_cnt = 0, m_cap = 0, m_ctrl = 0, m_ovf = 0, m_rx = 0, m_tx = 0;
  int          n_ovf = 0, n_rx = 0, n_tx = 0;

  always #5 ref_clk = ~ref_clk;

  tt2_timer i_tt2_timer (.ref_clk(ref_clk), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_sel(sfr_sel), .count_pin(count_pin), .trigger_pin(trigger_pin),
    .timer1_overflow(timer1_overflow), .rx_clock_pulse(rx_clock_pulse),
    .tx_clock_pulse(tx_clock_pulse), .overflow_pulse(overflow_pulse),
    .overflow_flag(overflow_flag), .external_flag(external_flag));
  tt2_pins i_tt2_pins (.ref_clk(ref_clk), .count_pin(count_pin), .trigger_pin(trigger_pin),
    .timer1_overflow(timer1_overflow));

  // pulses last one cycle, so tally them rather than sample them later;
  // the falling edge sees them settled, away from the edge that launches them
  always @(negedge ref_clk) begin
    if (rx_clock_pulse === 1'b1) n_rx++;
    if (tx_clock_pulse === 1'b1) n_tx++;
    if (overflow_pulse === 1'b1) n_ovf++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    rv = sfr_rdata;
    chk(16'(rv), 16'(exp));
  endtask

  task automatic set(input logic [7:0] c, input int cnt, input logic [15:0] cap);
    m_ctrl = c;
    m_cnt = cnt;
    m_cap = cap;
    wr(tt2_pkg::ADDR_CTRL, c);
    wr(tt2_pkg::ADDR_CAP_LO, cap[7:0]);
    wr(tt2_pkg::ADDR_CAP_HI, cap[15:8]);
    wr(tt2_pkg::ADDR_CNT_LO, 8'(cnt));
    wr(tt2_pkg::ADDR_CNT_HI, 8'(cnt >> 8));
  endtask

  // reference model of one falling edge: 0 count pin, 1 trigger pin
  task automatic m_edge(input int pin);
    bit baud;
    baud = m_ctrl[5] | m_ctrl[4];
    if (pin == 0 && m_ctrl[2] && m_ctrl[1]) begin
      if (m_cnt == 'hffff) begin
        m_ovf++;
        m_rx += m_ctrl[5];
        m_tx += m_ctrl[4];
        if (!baud) m_ctrl |= 'h80;
        m_cnt = (baud || !m_ctrl[0]) ? m_cap : 0;
      end else m_cnt++;
    end else if (pin == 1 && m_ctrl[3]) begin
      m_ctrl |= 'h40;
      if (!baud && m_ctrl[0]) m_cap = m_cnt;
      else if (!baud) m_cnt = m_cap;
    end
    i_tt2_pins.fall(pin, 2 + pin);
  endtask

  task automatic chk_all();
    repeat (4) @(negedge ref_clk);
    rd(tt2_pkg::ADDR_CTRL, 8'(m_ctrl));
    rd(tt2_pkg::ADDR_CAP_LO, 8'(m_cap));
    rd(tt2_pkg::ADDR_CAP_HI, 8'(m_cap >> 8));
    rd(tt2_pkg::ADDR_CNT_LO, 8'(m_cnt));
    rd(tt2_pkg::ADDR_CNT_HI, 8'(m_cnt >> 8));
    chk(16'(sfr_sel), 16'h0001);
    chk({overflow_flag, external_flag}, 16'(m_ctrl >> 6));
    chk(16'(n_rx), 16'(m_rx));
    chk(16'(n_tx), 16'(m_tx));
    chk(16'(n_ovf), 16'(m_ovf));
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    miscompares++;
    results();
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    chk_all();
    // unmapped place: write ignored, read gives idle data
    wr(8'hc9, 8'hff);
    rd(8'hc9, 8'h00);
    chk(16'(sfr_sel), 16'h0000);
    for (int i = 0; i < 7; i++) begin
      set(modes[i], 'hfffd + int'(xs() % 3), 16'(xs()));
      m_edge(0);
      m_edge(0);
      m_edge(1);
      m_edge(0);
      m_edge(0);
      i_tt2_pins.t1_pulse();
      m_rx += !m_ctrl[5];
      m_tx += !m_ctrl[4];
      chk_all();
      m_ctrl &= 'h3f;
      wr(tt2_pkg::ADDR_CTRL, 8'(m_ctrl));
      rd(tt2_pkg::ADDR_CTRL, 8'(m_ctrl));
    end
    // core clock counting; start edge latency leaves one cycle of slack
    set(8'h00, 0, 16'h0000);
    wr(tt2_pkg::ADDR_CTRL, 8'h04);
    repeat (20) @(negedge ref_clk);
    wr(tt2_pkg::ADDR_CTRL, 8'h00);
    rd(tt2_pkg::ADDR_CNT_LO, 8'd22);
    chk(16'(rv inside {[8'd21 : 8'd23]}), 16'h0001);
    results();
  end
endmodule
